/* pkg/dsct_chan_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface dsct_chan_if;
  logic        load;
  logic        srcStep;
  logic        dstStep;
  logic [2:0]  srcBytes;
  logic [2:0]  dstBytes;
  logic [6:0]  decAmt;
  logic [15:0] limit;
  logic [31:0] baseSrc;
  logic [31:0] baseDst;
  logic [15:0] remaining;
  logic [31:0] srcCur;
  logic [31:0] dstCur;

  modport ctl (output load, srcStep, dstStep, srcBytes, dstBytes, decAmt,
               limit, baseSrc, baseDst,
               input remaining, srcCur, dstCur);
  modport chan (input load, srcStep, dstStep, srcBytes, dstBytes, decAmt,
                limit, baseSrc, baseDst,
                output remaining, srcCur, dstCur);
endinterface
`default_nettype wire

/* pkg/dsct_pkg.sv */
package dsct_pkg;

  // register offsets
  localparam logic [7:0] OFF_DHI2 = 8'h8C;
  localparam logic [7:0] OFF_MAX2 = 8'h90;
  localparam logic [7:0] OFF_CTL2 = 8'h94;
  localparam logic [7:0] OFF_TC2  = 8'hA8;
  localparam logic [7:0] OFF_DHI3 = 8'hCC;
  localparam logic [7:0] OFF_MAX3 = 8'hD0;
  localparam logic [7:0] OFF_CTL3 = 8'hD4;
  localparam logic [7:0] OFF_TC3  = 8'hE8;

  // reset value of every register
  localparam logic [15:0] REG_RST = 16'h0000;

  // control field positions
  localparam int BIT_EN   = 0;
  localparam int BIT_SINC = 1;
  localparam int BIT_DINC = 2;
  localparam int SW_LO    = 3;
  localparam int BU_LO    = 5;
  localparam int DW_LO    = 7;
  localparam int BIT_CIRC = 9;
  localparam int BIT_M2M  = 11;
  localparam int BIT_DIR  = 13;

  // writable bits per control register
  localparam logic [15:0] CTL2_MASK = 16'h23FF;
  localparam logic [15:0] CTL3_MASK = 16'h2BFF;

  // byte staging buffer
  localparam int FIFO_BYTES = 64;
  localparam int FILL_W     = 7;

  typedef enum logic [1:0] {ST_IDLE, ST_READ, ST_WRITE, ST_FIN} dsct_state_t;

  // width code to bytes: 0 byte, 1 half-word, else word
  function automatic logic [2:0] bytesOf(input logic [1:0] code);
    bytesOf = (code == 2'h0) ? 3'h1 : (code == 2'h1) ? 3'h2 : 3'h4;
  endfunction

  // burst code to units
  function automatic logic [4:0] burstLen(input logic [1:0] code);
    case (code)
      2'h0:    burstLen = 5'h01;
      2'h1:    burstLen = 5'h04;
      2'h2:    burstLen = 5'h08;
      default: burstLen = 5'h10;
    endcase
  endfunction

endpackage

/* verification/dsct_bus_mem.sv */
`timescale 1ns/100ps
`default_nettype none
module dsct_bus_mem (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // system bus
  input  wire logic        busValid,
  input  wire logic        busWrite,
  input  wire logic [31:0] busAddr,
  input  wire logic [1:0]  busSize,
  input  wire logic [31:0] busWdata,
  output logic             busReady,
  output logic      [31:0] busRdata,
  // wait states before each ready
  input  wire logic [3:0]  waitCyc
);
  logic [3:0]  waitCnt_r;
  logic [7:0]  a0;
  logic [31:0] pat;
  logic [31:0] rdLog[$];
  logic [31:0] wrAddr[$];
  logic [31:0] wrData[$];
  logic [1:0]  wrSize[$];
  // byte k of a word holds the low address byte plus k
  assign a0 = busAddr[7:0];
  assign pat = {a0 + 8'h03, a0 + 8'h02, a0 + 8'h01, a0};
  assign busReady = busValid && waitCnt_r == waitCyc;
  // off-beat data inverted so stale lanes never look valid
  assign busRdata = (busReady && !busWrite) ? pat : ~pat;
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      waitCnt_r <= 4'h0;
    end else begin
      waitCnt_r <= (busValid && !busReady) ? waitCnt_r + 4'h1 : 4'h0;
      if (busReady && !busWrite) rdLog.push_back(busAddr);
      if (busReady && busWrite) begin
        wrAddr.push_back(busAddr);
        wrData.push_back(busWdata);
        wrSize.push_back(busSize);
      end
    end
  end
endmodule
`default_nettype wire

/* verification/dsct_dma_props.sv */
`timescale 1ns/100ps
`default_nettype none
module dsct_dma_props (
  // clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // register port
  input wire logic [7:0]  regAddr,
  input wire logic [15:0] regWrData,
  input wire logic        regWr,
  input wire logic        regRd,
  input wire logic [15:0] regRdData,
  // system bus
  input wire logic        busValid,
  input wire logic        busWrite,
  input wire logic [31:0] busAddr,
  input wire logic [1:0]  busSize,
  input wire logic        busReady,
  // status
  input wire logic [1:0]  streamActive,
  input wire logic [1:0]  streamDone
);
  logic [15:0] ctl2Sh_r;
  logic [15:0] ctl3Sh_r;
  logic [15:0] max2Sh_r;
  wire logic        wrCtl2 = regWr && regAddr == dsct_pkg::OFF_CTL2;
  wire logic [15:0] ctl3Hi = ctl3Sh_r & 16'hFFFE;
  // shadow copies of what software last wrote
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctl2Sh_r <= 16'h0000;
      ctl3Sh_r <= 16'h0000;
      max2Sh_r <= 16'h0000;
    end else begin
      if (wrCtl2) ctl2Sh_r <= regWrData & dsct_pkg::CTL2_MASK;
      if (regWr && regAddr == dsct_pkg::OFF_CTL3)
        ctl3Sh_r <= regWrData & dsct_pkg::CTL3_MASK;
      if (regWr && regAddr == dsct_pkg::OFF_MAX2) max2Sh_r <= regWrData;
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  property p_enable;
    wrCtl2 && regWrData[0] && !streamActive[0] |=> streamActive[0];
  endproperty
  a_enable: assert property (p_enable) else $error("enable ignored");
  property p_load;
    wrCtl2 && regWrData[0] && !streamActive[0]
      ##2 regRd && regAddr == dsct_pkg::OFF_TC2 |=> regRdData == max2Sh_r;
  endproperty
  a_load: assert property (p_load) else $error("count not loaded");
  property p_stand;
    busValid && !busReady |=> busValid && $stable(busAddr)
      && $stable(busSize) && $stable(busWrite);
  endproperty
  a_stand: assert property (p_stand) else $error("bus beat moved");
  property p_copy;
    $rose(streamActive[1]) && ctl3Sh_r[11] && !streamActive[0]
      |-> ##[1:4] busValid;
  endproperty
  a_copy: assert property (p_copy) else $error("copy did not start");
  property p_srcSize;
    busValid && !busWrite && streamActive == 2'h1 && ctl2Sh_r[4:3] != 2'h3
      |-> busSize == ctl2Sh_r[4:3];
  endproperty
  a_srcSize: assert property (p_srcSize) else $error("read size");
  property p_dstSize;
    busValid && busWrite && streamActive == 2'h1 && ctl2Sh_r[8:7] != 2'h3
      |-> busSize == ctl2Sh_r[8:7];
  endproperty
  a_dstSize: assert property (p_dstSize) else $error("write size");
  property p_done;
    streamDone[0] |-> !streamActive[0] ##1 !streamDone[0];
  endproperty
  a_done: assert property (p_done) else $error("done pulse");
  property p_circ;
    ctl2Sh_r[9] |-> !streamDone[0];
  endproperty
  a_circ: assert property (p_circ) else $error("circular ended");
  property p_ctlRd;
    $past(regRd) && $past(regAddr) == dsct_pkg::OFF_CTL3
      |-> (regRdData & 16'hFFFE) == $past(ctl3Hi);
  endproperty
  a_ctlRd: assert property (p_ctlRd) else $error("control readback");
  c_done2: cover property (streamDone[0]);
  c_done3: cover property (streamDone[1]);
  c_stall: cover property (busValid && busWrite && !busReady);
endmodule
bind dsct_dma_top dsct_dma_props chk (.clk_sys, .rst_b, .regAddr,
  .regWrData, .regWr, .regRd, .regRdData, .busValid, .busWrite, .busAddr,
  .busSize, .busReady, .streamActive, .streamDone);
`default_nettype wire

/* verification/dsct_dma_top_tb.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (g), (e)); end end
module dsct_dma_top_tb;
  typedef struct {
    int s; logic [15:0] ctl; logic [15:0] max;
    int nRd; int sb; int nWr; int db; logic dinc; logic [3:0] wt;
  } dsct_row_t;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  regAddr = 8'h00;
  logic [15:0] regWrData = 16'h0000;
  logic        regWr = 1'b0;
  logic        regRd = 1'b0;
  logic [1:0]  dmaReq = 2'h0;
  logic [31:0] srcBase2 = 32'h1000_0010;
  logic [31:0] srcBase3 = 32'h3000_0020;
  logic [15:0] destLow2 = 16'h0100;
  logic [15:0] destLow3 = 16'h0200;
  logic [3:0]  waitCyc = 4'h0;
  logic [15:0] regRdData;
  logic        busValid, busWrite, busReady;
  logic [31:0] busAddr, busWdata, busRdata;
  logic [1:0]  busSize, streamActive, streamDone;
  int          compares = 0;
  int          miscompares = 0;
  dsct_row_t   rows[5] = '{
    '{0, 16'h0037, 16'h0003, 3, 4, 12, 1, 1'b1, 4'h2},
    '{0, 16'h2083, 16'h0002, 4, 1, 2, 2, 1'b0, 4'h0},
    '{1, 16'h292F, 16'h0004, 4, 2, 2, 4, 1'b1, 4'h1},
    '{0, 16'h0047, 16'h000A, 10, 1, 10, 1, 1'b1, 4'h0},
    '{1, 16'h0177, 16'h0002, 2, 4, 2, 4, 1'b1, 4'h3}};
  dsct_dma_top uut (.clk_sys, .rst_b, .regAddr, .regWrData, .regWr, .regRd,
    .regRdData, .dmaReq, .srcBase2, .srcBase3, .destLow2, .destLow3,
    .busValid, .busWrite, .busAddr, .busSize, .busWdata, .busReady,
    .busRdata, .streamActive, .streamDone);
  dsct_bus_mem mdl (.clk_sys, .rst_b, .busValid, .busWrite, .busAddr,
    .busSize, .busWdata, .busReady, .busRdata, .waitCyc);
  always #20 clk_sys = ~clk_sys;
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    // idle edge, so a following strobe is a fresh assignment
    @(posedge clk_sys);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [15:0] e);
    logic [15:0] d;
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk_sys);
    regRd <= 1'b0;
    @(negedge clk_sys);
    d = regRdData;
    @(posedge clk_sys);
    `CHK(d, e)
  endtask
  // wait on negedges for a status bit, bounded
  task automatic waitBit(input int s, input logic done);
    int n;
    n = 0;
    do begin
      @(negedge clk_sys);
      n++;
    end while ((done ? streamDone[s] : !streamActive[s]) !== 1'b1 && n < 400);
    @(posedge clk_sys);
    `CHK(n < 400, 1'b1)
  endtask
  task automatic xfer(input dsct_row_t r);
    logic [7:0]  o;
    logic [31:0] src, dst, m, e;
    o = (r.s == 0) ? 8'h00 : 8'h40;
    src = (r.s == 0) ? srcBase2 : srcBase3;
    dst = {16'h2000, (r.s == 0) ? destLow2 : destLow3};
    m = (r.db == 4) ? 32'hFFFFFFFF : (r.db == 2) ? 32'h0000FFFF : 32'h000000FF;
    waitCyc <= r.wt;
    mdl.rdLog.delete();
    mdl.wrAddr.delete();
    mdl.wrData.delete();
    mdl.wrSize.delete();
    wr(dsct_pkg::OFF_DHI2 + o, 16'h2000);
    wr(dsct_pkg::OFF_MAX2 + o, r.max);
    wr(dsct_pkg::OFF_CTL2 + o, r.ctl);
    rdChk(dsct_pkg::OFF_TC2 + o, r.max);
    repeat (4) @(posedge clk_sys);
    if (!r.ctl[11]) begin
      `CHK(mdl.rdLog.size(), 0)
      dmaReq[r.s] <= 1'b1;
    end
    waitBit(r.s, 1'b1);
    dmaReq <= 2'h0;
    `CHK(mdl.rdLog.size(), r.nRd)
    `CHK(mdl.wrAddr.size(), r.nWr)
    for (int k = 0; k < r.nRd && k < mdl.rdLog.size(); k++) begin
      `CHK(mdl.rdLog[k], src + 32'(k * r.sb))
    end
    for (int k = 0; k < r.nWr && k < mdl.wrAddr.size(); k++) begin
      e = 32'h0;
      for (int b = 0; b < r.db; b++) e[8*b +: 8] = 8'(src[7:0] + k*r.db + b);
      `CHK(mdl.wrAddr[k], dst + 32'(r.dinc ? k * r.db : 0))
      `CHK(mdl.wrData[k] & m, e)
      `CHK(mdl.wrSize[k], r.ctl[8:7])
    end
    `CHK(streamActive[r.s], 1'b0)
    rdChk(dsct_pkg::OFF_CTL2 + o, r.ctl & 16'hFFFE);
  endtask
  task automatic summarize;
    if (miscompares == 0 && compares > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    summarize();
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    foreach (rows[i]) xfer(rows[i]);
    // reserved control bits and read-only count
    wr(dsct_pkg::OFF_CTL2, 16'hFFFE);
    rdChk(dsct_pkg::OFF_CTL2, 16'hFFFE & dsct_pkg::CTL2_MASK);
    wr(dsct_pkg::OFF_CTL3, 16'hFFFE);
    rdChk(dsct_pkg::OFF_CTL3, 16'hFFFE & dsct_pkg::CTL3_MASK);
    wr(dsct_pkg::OFF_TC3, 16'h5A5A);
    rdChk(dsct_pkg::OFF_TC3, 16'h0000);
    wr(8'h10, 16'hFFFF);
    rdChk(8'h10, 16'h0000);
    wr(dsct_pkg::OFF_CTL3, 16'h0000);
    // circular sweep reloads count and source address
    mdl.rdLog.delete();
    wr(dsct_pkg::OFF_MAX2, 16'h0001);
    wr(dsct_pkg::OFF_CTL2, 16'h0203);
    dmaReq <= 2'h1;
    repeat (30) @(posedge clk_sys);
    `CHK(mdl.rdLog.size() > 2, 1'b1)
    `CHK(mdl.rdLog[2], srcBase2)
    wr(dsct_pkg::OFF_CTL2, 16'h0000);
    dmaReq <= 2'h0;
    waitBit(0, 1'b0);
    `CHK(streamActive[0], 1'b0)
    // let the burst in flight drain before touching the control word
    repeat (10) @(posedge clk_sys);
    @(negedge clk_sys);
    `CHK(busValid, 1'b0)
    @(posedge clk_sys);
    // reset in mid-transfer clears every register
    wr(dsct_pkg::OFF_CTL2, 16'h0037);
    dmaReq <= 2'h1;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b0;
    dmaReq <= 2'h0;
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    `CHK(streamActive, 2'h0)
    for (int i = 0; i < 8; i++) begin
      rdChk(8'h8C + 8'(i * 4), dsct_pkg::REG_RST);
      rdChk(8'hCC + 8'(i * 4), dsct_pkg::REG_RST);
    end
    summarize();
  end
endmodule
`default_nettype wire

/* verilog/dsct_chan.sv */
`timescale 1ns/100ps
`default_nettype none
module dsct_chan (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_b,
  // stream counters
  dsct_chan_if.chan bus
);

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bus.remaining <= dsct_pkg::REG_RST;
      bus.srcCur    <= 32'h00000000;
      bus.dstCur    <= 32'h00000000;
    end else if (bus.load) begin
      bus.remaining <= bus.limit;
      bus.srcCur    <= bus.baseSrc;
      bus.dstCur    <= bus.baseDst;
    end else begin
      if (bus.srcStep) begin
        bus.srcCur <= bus.srcCur + 32'(bus.srcBytes);
      end
      if (bus.dstStep) begin
        bus.dstCur <= bus.dstCur + 32'(bus.dstBytes);
      end
      bus.remaining <= bus.remaining - 16'(bus.decAmt);
    end
  end

endmodule
`default_nettype wire

/* verilog/dsct_dma_top.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - control bit 0 enables the stream; clearing it stops the stream
// - enabling a stream loads its unit limit into remaining units
// - 16-bit unit limit counts data units, unit chosen by direction
// - source-increment bit advances source address per source read
// - destination-increment bit advances destination address per write
// - source width field: byte, half-word, word; code 11 reserved
// - destination width field bits 8:7, same encoding
// - burst field: single, 4, 8 or 16 incrementing units
// - peripheral as source: gather a whole burst, or the remaining units if fewer, before writing out
// - peripheral as destination: fetch source data for one dest burst
// - direction bit 13 picks which width is the unit
// - bit 9 selects circular buffer operation
// - stream 3 copy mode ignores request and runs until count expires
// - in copy mode the burst field sizes the source side
// - remaining units drop per unit buffered; at zero drain and end
// - addresses advance by transfer size when address phase ends
// - direction bit ignored in copy mode
module dsct_dma_top (
  // clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // register port
  input  wire logic [7:0]  regAddr,
  input  wire logic [15:0] regWrData,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic      [15:0] regRdData,
  // peripheral requests, bit 0 stream 2, bit 1 stream 3
  input  wire logic [1:0]  dmaReq,
  // base addresses held outside this block
  input  wire logic [31:0] srcBase2,
  input  wire logic [31:0] srcBase3,
  input  wire logic [15:0] destLow2,
  input  wire logic [15:0] destLow3,
  // system bus master
  output logic             busValid,
  output logic             busWrite,
  output logic      [31:0] busAddr,
  output logic      [1:0]  busSize,
  output logic      [31:0] busWdata,
  input  wire logic        busReady,
  input  wire logic [31:0] busRdata,
  // stream status
  output logic      [1:0]  streamActive,
  output logic      [1:0]  streamDone
);

  // register storage
  logic [15:0] ctrl_r     [2];
  logic [15:0] ctrl_nxt   [2];
  logic [15:0] limit_r    [2];
  logic [15:0] destHi_r   [2];
  logic [1:0]  active_r;
  logic [1:0]  active_nxt;
  logic [1:0]  done_r;
  logic [15:0] rdData_r;

  // per-stream decode
  logic [1:0]  wrCtl;
  logic [1:0]  wrMax;
  logic [1:0]  wrDhi;
  logic [1:0]  enRise;
  logic [1:0]  finEv;
  logic [1:0]  stopEv;
  logic [1:0]  loadEv;
  logic [1:0]  circ;
  logic [1:0]  m2m;
  logic [1:0]  want;
  logic [15:0] ctrlWr     [2];
  logic [1:0]  srcW       [2];
  logic [1:0]  dstW       [2];
  logic [1:0]  unitCode   [2];
  logic [6:0]  tgtBytes   [2];
  logic [15:0] remaining  [2];
  logic [31:0] srcCur     [2];
  logic [31:0] dstCur     [2];

  // transfer sequencer
  dsct_pkg::dsct_state_t state_r;
  dsct_pkg::dsct_state_t state_nxt;
  logic                  sel_r;
  logic                  sel_nxt;
  logic [6:0]            fill_r;
  logic [6:0]            fill_nxt;
  logic [6:0]            tgt_r;
  logic [6:0]            tgt_nxt;
  logic [6:0]            ptr_r;
  logic [6:0]            ptr_nxt;
  logic [7:0]            fifoMem [dsct_pkg::FIFO_BYTES];

  // selected stream view
  logic       inRead;
  logic       inWrite;
  logic       rdDone;
  logic       wrDone;
  logic       pick;
  logic [2:0] selSrcB;
  logic [2:0] selDstB;
  logic [1:0] selUnit;
  logic [6:0] fillAdd;
  logic [6:0] ptrAdd;
  logic [6:0] decUnits;
  logic       readLast;
  logic       writeLast;
  logic       selRemZero;
  logic [15:0] rdMux;
  logic [31:0] wdata;

  generate
    for (genvar s = 0; s < 2; s++) begin : g_str
      localparam logic [7:0] OFF_CTL =
        (s == 0) ? dsct_pkg::OFF_CTL2 : dsct_pkg::OFF_CTL3;
      localparam logic [7:0] OFF_MAX =
        (s == 0) ? dsct_pkg::OFF_MAX2 : dsct_pkg::OFF_MAX3;
      localparam logic [7:0] OFF_DHI =
        (s == 0) ? dsct_pkg::OFF_DHI2 : dsct_pkg::OFF_DHI3;
      localparam logic [15:0] MASK =
        (s == 0) ? dsct_pkg::CTL2_MASK : dsct_pkg::CTL3_MASK;

      wire logic [4:0] burst;
      wire logic [4:0] tgtUnits;
      wire logic       srcInc;
      wire logic       dstInc;

      dsct_chan_if chIf ();

      dsct_chan u_chan (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .bus     (chIf.chan)
      );

      assign wrCtl[s]  = regWr && (regAddr == OFF_CTL);
      assign wrMax[s]  = regWr && (regAddr == OFF_MAX);
      assign wrDhi[s]  = regWr && (regAddr == OFF_DHI);
      // reserved bits never stored, read back as zero
      assign ctrlWr[s] = regWrData & MASK;

      assign enRise[s] = wrCtl[s] && ctrlWr[s][dsct_pkg::BIT_EN]
                         && !ctrl_r[s][dsct_pkg::BIT_EN];
      assign circ[s]   = ctrl_r[s][dsct_pkg::BIT_CIRC];
      assign finEv[s]  = (state_r == dsct_pkg::ST_FIN) && (sel_r == s)
                         && active_r[s];
      assign stopEv[s] = finEv[s] && !circ[s];
      // circular streams restart the sweep on their own
      assign loadEv[s] = enRise[s] || (finEv[s] && circ[s]);

      assign srcW[s] = ctrl_r[s][dsct_pkg::SW_LO +: 2];
      assign dstW[s] = ctrl_r[s][dsct_pkg::DW_LO +: 2];
      if (s == 1) begin : g_m2m
        assign m2m[s] = ctrl_r[s][dsct_pkg::BIT_M2M];
      end else begin : g_nom2m
        assign m2m[s] = 1'b0;
      end
      // copy mode forces the source width as unit
      assign unitCode[s] = (m2m[s] || !ctrl_r[s][dsct_pkg::BIT_DIR])
                           ? srcW[s] : dstW[s];
      assign burst    = dsct_pkg::burstLen(
                          ctrl_r[s][dsct_pkg::BU_LO +: 2]);
      assign tgtUnits = (remaining[s] < 16'(burst))
                        ? remaining[s][4:0] : burst;
      // bytes gathered before draining: one burst of units, or the remaining units if fewer
      assign tgtBytes[s] = 7'(7'(tgtUnits) << unitCode[s]);

      // copy mode needs no request
      assign want[s] = active_r[s] && (dmaReq[s] || m2m[s]);

      assign srcInc = ctrl_r[s][dsct_pkg::BIT_SINC];
      assign dstInc = ctrl_r[s][dsct_pkg::BIT_DINC];

      assign chIf.load     = loadEv[s];
      assign chIf.limit    = limit_r[s];
      assign chIf.baseSrc  = (s == 0) ? srcBase2 : srcBase3;
      assign chIf.baseDst  = (s == 0) ? {destHi_r[s], destLow2}
                                      : {destHi_r[s], destLow3};
      assign chIf.srcBytes = dsct_pkg::bytesOf(srcW[s]);
      assign chIf.dstBytes = dsct_pkg::bytesOf(dstW[s]);
      assign chIf.srcStep  = rdDone && (sel_r == s) && srcInc;
      assign chIf.dstStep  = wrDone && (sel_r == s) && dstInc;
      assign chIf.decAmt   = (rdDone && (sel_r == s))
                             ? decUnits : 7'h00;
      assign remaining[s]  = chIf.remaining;
      assign srcCur[s]     = chIf.srcCur;
      assign dstCur[s]     = chIf.dstCur;

      // software write wins over the end-of-transfer clear of bit 0, not over the active_r clear
      always_comb begin
        if (wrCtl[s]) begin
          ctrl_nxt[s] = ctrlWr[s];
        end else if (stopEv[s]) begin
          ctrl_nxt[s] = ctrl_r[s] & ~(16'h0001 << dsct_pkg::BIT_EN);
        end else begin
          ctrl_nxt[s] = ctrl_r[s];
        end
      end

      always_comb begin
        if (wrCtl[s]) begin
          active_nxt[s] = enRise[s] || (ctrlWr[s][dsct_pkg::BIT_EN]
                          && active_r[s] && !stopEv[s]);
        end else if (stopEv[s]) begin
          active_nxt[s] = 1'b0;
        end else begin
          active_nxt[s] = active_r[s];
        end
      end

      always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
          ctrl_r[s]   <= dsct_pkg::REG_RST;
          limit_r[s]  <= dsct_pkg::REG_RST;
          destHi_r[s] <= dsct_pkg::REG_RST;
        end else begin
          ctrl_r[s] <= ctrl_nxt[s];
          if (wrMax[s]) begin
            limit_r[s] <= regWrData;
          end
          if (wrDhi[s]) begin
            destHi_r[s] <= regWrData;
          end
        end
      end
    end
  endgenerate

  // selected stream
  assign inRead     = (state_r == dsct_pkg::ST_READ);
  assign inWrite    = (state_r == dsct_pkg::ST_WRITE);
  assign rdDone     = inRead && busReady;
  assign wrDone     = inWrite && busReady;
  assign pick       = !want[0];
  assign selSrcB    = dsct_pkg::bytesOf(srcW[sel_r]);
  assign selDstB    = dsct_pkg::bytesOf(dstW[sel_r]);
  assign selUnit    = unitCode[sel_r];
  assign fillAdd    = fill_r + 7'(selSrcB);
  assign ptrAdd     = ptr_r + 7'(selDstB);
  // units completed by this read
  assign decUnits   = (fillAdd >> selUnit) - (fill_r >> selUnit);
  assign readLast   = (fillAdd >= tgt_r);
  assign writeLast  = (ptrAdd >= fill_r);
  assign selRemZero = (remaining[sel_r] == 16'h0000);

  always_comb begin
    state_nxt = state_r;
    sel_nxt   = sel_r;
    fill_nxt  = fill_r;
    tgt_nxt   = tgt_r;
    ptr_nxt   = ptr_r;
    case (state_r)
      dsct_pkg::ST_IDLE: begin
        if (|want) begin
          sel_nxt  = pick;
          fill_nxt = 7'h00;
          ptr_nxt  = 7'h00;
          tgt_nxt  = tgtBytes[pick];
          state_nxt = (remaining[pick] == 16'h0000)
                      ? dsct_pkg::ST_FIN : dsct_pkg::ST_READ;
        end
      end
      dsct_pkg::ST_READ: begin
        if (busReady) begin
          fill_nxt = fillAdd;
          if (readLast) begin
            state_nxt = dsct_pkg::ST_WRITE;
          end
        end
      end
      dsct_pkg::ST_WRITE: begin
        if (busReady) begin
          ptr_nxt = ptrAdd;
          if (writeLast) begin
            // drained; count at zero ends the transfer
            state_nxt = selRemZero
                        ? dsct_pkg::ST_FIN : dsct_pkg::ST_IDLE;
          end
        end
      end
      dsct_pkg::ST_FIN: begin
        state_nxt = dsct_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = dsct_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_r <= dsct_pkg::ST_IDLE;
      sel_r   <= 1'b0;
      fill_r  <= 7'h00;
      tgt_r   <= 7'h00;
      ptr_r   <= 7'h00;
    end else begin
      state_r <= state_nxt;
      sel_r   <= sel_nxt;
      fill_r  <= fill_nxt;
      tgt_r   <= tgt_nxt;
      ptr_r   <= ptr_nxt;
    end
  end

  // source bytes land little-endian in the staging buffer
  always_ff @(posedge clk_sys) begin
    for (int k = 0; k < 4; k++) begin
      if (rdDone && (3'(k) < selSrcB)) begin
        fifoMem[6'(fill_r + 7'(k))] <= busRdata[8*k +: 8];
      end
    end
  end

  always_comb begin
    wdata = 32'h00000000;
    for (int k = 0; k < 4; k++) begin
      if (3'(k) < selDstB) begin
        wdata[8*k +: 8] = fifoMem[6'(ptr_r + 7'(k))];
      end
    end
  end

  // bus master
  assign busValid = inRead || inWrite;
  assign busWrite = inWrite;
  assign busAddr  = inWrite ? dstCur[sel_r] : srcCur[sel_r];
  assign busSize  = inWrite ? dstW[sel_r] : srcW[sel_r];
  assign busWdata = wdata;

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      active_r <= 2'h0;
      done_r   <= 2'h0;
    end else begin
      active_r <= active_nxt;
      done_r   <= stopEv;
    end
  end

  assign streamActive = active_r;
  assign streamDone   = done_r;

  // register read-back
  always_comb begin
    case (regAddr)
      dsct_pkg::OFF_DHI2: rdMux = destHi_r[0];
      dsct_pkg::OFF_MAX2: rdMux = limit_r[0];
      dsct_pkg::OFF_CTL2: rdMux = ctrl_r[0];
      dsct_pkg::OFF_TC2:  rdMux = remaining[0];
      dsct_pkg::OFF_DHI3: rdMux = destHi_r[1];
      dsct_pkg::OFF_MAX3: rdMux = limit_r[1];
      dsct_pkg::OFF_CTL3: rdMux = ctrl_r[1];
      dsct_pkg::OFF_TC3:  rdMux = remaining[1];
      default:            rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rdData_r <= 16'h0000;
    end else begin
      rdData_r <= regRd ? rdMux : 16'h0000;
    end
  end

  assign regRdData = rdData_r;

endmodule
`default_nettype wire
